// ### verilog/sat_pkg.sv
// Shared constants for the satellite bus slave and ROM decode
package sat_pkg;
    // Register map, byte addresses
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    // Control field positions
    localparam int CTRL_ROM2K_BIT = 0;
    localparam int CTRL_JMP_LSB   = 4;
    localparam int JMP_W          = 3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Status bit positions
    localparam int ST_IRQ_BIT   = 0;
    localparam int ST_HOLD_BIT  = 1;
    localparam int ST_DMA_BIT   = 2;
    localparam int ST_ROM_BIT   = 3;
    localparam int ST_WAIT_BIT  = 4;
    localparam int ST_POJ_BIT   = 5;
    localparam int ST_VI4_BIT   = 6;
    // ROM windows on the six top address bits
    localparam logic [15:0] ROM_BASE_1K = 16'hfc00;
    localparam logic [15:0] ROM_BASE_2K = 16'hf000;
    localparam logic [15:0] ROM_TOP     = 16'hffff;
    localparam int ROM_WAIT_CYCLES = 1;
    localparam int IRQ_ADDR_BIT    = 7;
    localparam int SEL_LINES       = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### verilog/ctl_if.sv
// Signals between the core and its decode helpers
`timescale 1ns/1ps
interface ctl_if;
    logic [5:0]                   addr_hi;
    logic                         rom_2k;
    logic                         power_on_jump_n;
    logic                         rom_hit;
    logic                         ram_disable;
    logic [sat_pkg::SEL_LINES-1:0] select_n;
    logic [sat_pkg::JMP_W-1:0]    jumper;
    logic                         hold_ack_n;
    logic                         hold_req;
    logic                         dma_active;
    modport core (output addr_hi, rom_2k, power_on_jump_n, select_n, jumper, hold_ack_n,
                  input rom_hit, ram_disable, hold_req, dma_active);
    modport rom_side (input addr_hi, rom_2k, power_on_jump_n, output rom_hit, ram_disable);
    modport dma_side (input select_n, jumper, hold_ack_n, output hold_req, dma_active);
endinterface

// ### verilog/rom_decode.sv
// ROM address match and RAM disable
`timescale 1ns/1ps
module rom_decode
(
    ctl_if.rom_side c
);
    logic match;
    always_comb
    begin
        if (c.rom_2k)
            match = c.addr_hi >= sat_pkg::ROM_BASE_2K[15:10];
        else
            match = c.addr_hi >= sat_pkg::ROM_BASE_1K[15:10];
    end
    // Jump input forces ROM regardless of address
    assign c.rom_hit     = match || !c.power_on_jump_n;
    assign c.ram_disable = match || !c.power_on_jump_n;
endmodule

// ### verilog/dma_select.sv
// Board select jumper, hold request and DMA window
`timescale 1ns/1ps
module dma_select
(
    ctl_if.dma_side c
);
    logic sel_n;
    // One inversion: hold request is high while the selected line is low
    assign sel_n        = c.select_n[c.jumper];
    assign c.hold_req   = !sel_n;
    assign c.dma_active = !sel_n && !c.hold_ack_n;
endmodule

// ### verilog/satellite_bus_slave.sv
// Satellite card memory control, ROM decode, DMA take-over and AXI4-Lite registers
// How it works
// - Column phase puts address bits 13..7 on RAM pins, row phase bits 6..0
// - Multiplexer moves to column bits one edge after the qualified request
// - Column strobe follows the multiplexer switch, drops when the request ends
// - ROM hit on top six bits: FC00-FFFF, or F000-FFFF with 2K option
// - ROM hit inhibits the RAM row strobe
// - Power-on-jump low disables RAM and selects ROM whatever the address
// - ROM chip select low only for ROM hit with qualified request
// - RAM runs without waits; ROM fetch stalls the processor one cycle
// - Wait held off until ROM hit and opcode fetch, then request clocks in
// - Master drives transfers; hold acknowledge opens the bus buffers
// - Software posts a mailbox message then strobes an output cycle
// - Output strobe with address bit 7 high toggles the shared interrupt
// - Hold request becoming active clears any pending interrupt; an output strobe in the same cycle sets it instead
// - One of eight select lines, chosen by jumper, starts a DMA
// - Selected line low gives an active hold request
// - Processor finishes, floats, keeps hold acknowledge low until released
// - During DMA the backplane strobes replace local read and memory request
// - During DMA read high drives toward backplane, low toward RAM
`timescale 1ns/1ps
module satellite_bus_slave
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] addr,
    input  wire logic        memory_request_n,
    input  wire logic        read_n,
    input  wire logic        opcode_fetch_cycle_n,
    input  wire logic        io_request_strobe_n,
    input  wire logic        power_on_jump_n,
    input  wire logic        cpu_hold_ack_n,
    input  wire logic [7:0]  satellite_select_n,
    input  wire logic        dma_mem_request_n,
    input  wire logic        dma_read_strobe,
    input  wire logic        vi4_i,
    output logic             vi4_o,
    output logic             vi4_oe,
    output logic [6:0]       ram_addr,
    output logic             addr_a,
    output logic             cas_n,
    output logic             ras_inhibit_n,
    output logic             qualified_mem_request,
    output logic             ram_read,
    output logic             rom_chip_select_n,
    output logic             wait_n,
    output logic             cpu_hold_request_n,
    output logic             dma_buffer_enable_n,
    output logic             data_to_backplane
);
    typedef enum logic [1:0] {ST_IDLE, ST_ROW, ST_COL} mem_e;

    mem_e        st_r;
    logic [31:0] ctrl_r;
    logic        irq_r;
    logic        io_prev_n_r;
    logic        hold_prev_r;
    logic        wait_done_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [3:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        mreq;
    logic        rd;
    logic        rom_sel;
    logic        m1;
    logic        io_evt;
    logic        hold_evt;
    logic [31:0] status;

    ctl_if c ();

    assign c.addr_hi         = addr[15:10];
    assign c.rom_2k          = ctrl_r[sat_pkg::CTRL_ROM2K_BIT];
    assign c.power_on_jump_n = power_on_jump_n;
    assign c.select_n        = satellite_select_n;
    assign c.jumper          = ctrl_r[sat_pkg::CTRL_JMP_LSB +: sat_pkg::JMP_W];
    assign c.hold_ack_n      = cpu_hold_ack_n;

    rom_decode u_rom
    (
        .c (c.rom_side)
    );

    dma_select u_dma
    (
        .c (c.dma_side)
    );

    // Backplane strobes take over during DMA
    assign mreq    = c.dma_active ? !dma_mem_request_n : !memory_request_n;
    assign rd      = c.dma_active ? dma_read_strobe : !read_n;
    assign m1      = !opcode_fetch_cycle_n && !c.dma_active;
    assign rom_sel = c.rom_hit;
    assign io_evt  = io_prev_n_r && !io_request_strobe_n && addr[sat_pkg::IRQ_ADDR_BIT];
    assign hold_evt = c.hold_req && !hold_prev_r;

    // RAM cycle: request, row phase, column phase
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r                  <= ST_IDLE;
            qualified_mem_request <= 1'b0;
            addr_a                <= 1'b1;
            cas_n                 <= 1'b1;
            ram_addr              <= 7'h00;
        end
        else if (ce)
        begin
            if (!mreq)
            begin
                st_r                  <= ST_IDLE;
                qualified_mem_request <= 1'b0;
                addr_a                <= 1'b1;
                cas_n                 <= 1'b1;
                ram_addr              <= addr[6:0];
            end
            else
            begin
                unique case (st_r)
                    ST_IDLE:
                    begin
                        st_r                  <= ST_ROW;
                        qualified_mem_request <= 1'b1;
                        ram_addr              <= addr[6:0];
                    end
                    ST_ROW:
                    begin
                        st_r     <= ST_COL;
                        addr_a   <= 1'b0;
                        ram_addr <= addr[13:7];
                    end
                    ST_COL:
                    begin
                        cas_n    <= 1'b0;
                        ram_addr <= addr[13:7];
                    end
                endcase
            end
        end
    end

    // ROM select and RAM row inhibit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ras_inhibit_n     <= 1'b1;
            rom_chip_select_n <= 1'b1;
            ram_read          <= 1'b0;
        end
        else if (ce)
        begin
            ras_inhibit_n     <= !c.ram_disable;
            rom_chip_select_n <= !(rom_sel && qualified_mem_request);
            ram_read          <= rd;
        end
    end

    // One wait cycle on ROM opcode fetch, none on RAM
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wait_n      <= 1'b1;
            wait_done_r <= 1'b0;
        end
        else if (ce)
        begin
            if (!(rom_sel && m1))
            begin
                wait_n      <= 1'b1;
                wait_done_r <= 1'b0;
            end
            else if (mreq && !wait_done_r)
            begin
                wait_n      <= 1'b0;
                wait_done_r <= 1'b1;
            end
            else
            begin
                wait_n <= 1'b1;
                if (!mreq)
                    wait_done_r <= 1'b0;
            end
        end
    end

    // Hold request, buffer enable and transceiver direction
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_hold_request_n  <= 1'b1;
            dma_buffer_enable_n <= 1'b1;
            data_to_backplane   <= 1'b0;
        end
        else if (ce)
        begin
            cpu_hold_request_n  <= !c.hold_req;
            dma_buffer_enable_n <= !c.dma_active;
            data_to_backplane   <= c.dma_active && dma_read_strobe;
        end
    end

    // Shared interrupt flag; a strobe in the clearing cycle still counts
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_r       <= 1'b0;
            io_prev_n_r <= 1'b1;
            hold_prev_r <= 1'b0;
            vi4_oe      <= 1'b0;
        end
        else if (ce)
        begin
            io_prev_n_r <= io_request_strobe_n;
            hold_prev_r <= c.hold_req;
            if (io_evt && hold_evt)
            begin
                irq_r  <= 1'b1;
                vi4_oe <= 1'b1;
            end
            else if (io_evt)
            begin
                irq_r  <= !irq_r;
                vi4_oe <= !irq_r;
            end
            else if (hold_evt)
            begin
                irq_r  <= 1'b0;
                vi4_oe <= 1'b0;
            end
        end
    end

    assign vi4_o = 1'b0;

    assign status = {25'h0, vi4_i, !power_on_jump_n, !wait_n, rom_sel,
                     c.dma_active, c.hold_req, irq_r};

    // AXI4-Lite write: address and data in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= sat_pkg::RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= 4'h0;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            ctrl_r        <= sat_pkg::CTRL_RST;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            else if (!aw_got_r && !s_axi_bvalid)
                s_axi_awready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r      <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            else if (!w_got_r && !s_axi_bvalid)
                s_axi_wready <= 1'b1;
            if (aw_got_r && w_got_r && !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                if (awaddr_r == sat_pkg::CTRL_OFS)
                begin
                    s_axi_bresp <= sat_pkg::RESP_OKAY;
                    if (wstrb_r[0])
                        ctrl_r[7:0] <= wdata_r[7:0];
                end
                else if (awaddr_r == sat_pkg::STAT_OFS)
                    s_axi_bresp <= sat_pkg::RESP_OKAY;
                else
                    s_axi_bresp <= sat_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
            end
        end
    end

    // AXI4-Lite read
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= sat_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                if (s_axi_araddr == sat_pkg::CTRL_OFS)
                begin
                    s_axi_rdata <= {24'h0, ctrl_r[7:0]};
                    s_axi_rresp <= sat_pkg::RESP_OKAY;
                end
                else if (s_axi_araddr == sat_pkg::STAT_OFS)
                begin
                    s_axi_rdata <= status;
                    s_axi_rresp <= sat_pkg::RESP_OKAY;
                end
                else
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= sat_pkg::RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            else if (!s_axi_rvalid)
                s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    sequence row_s;
        st_r == ST_ROW && mreq && ce;
    endsequence

    sequence col_s;
        !addr_a && ram_addr == $past(addr[13:7]);
    endsequence

    mux_switch_a: assert property (row_s |=> col_s)
        else $error("multiplexer not at column bits after row phase");
    cas_after_mux_a: assert property ($fell(cas_n) |-> $past(!addr_a) && !addr_a)
        else $error("column strobe before multiplexer switch");
    cas_release_a: assert property (!mreq && ce |=> cas_n && addr_a && !qualified_mem_request)
        else $error("column strobe held after request end");
    row_inhibit_a: assert property ((c.rom_hit || !power_on_jump_n) && ce |=> !ras_inhibit_n)
        else $error("RAM row strobe not inhibited");
    rom_select_a: assert property (!rom_chip_select_n |-> $past(rom_sel && qualified_mem_request))
        else $error("ROM select without hit and request");
    wait_single_a: assert property ($fell(wait_n) |=> wait_n)
        else $error("wait longer than one cycle");
    wait_preset_a: assert property (!wait_n |-> $past(rom_sel && m1 && mreq))
        else $error("wait without ROM opcode fetch");
    hold_follow_a: assert property (!satellite_select_n[c.jumper] && ce |=> !cpu_hold_request_n)
        else $error("hold request missing for selected line");
    irq_clear_a: assert property (hold_evt && !io_evt && ce |=> !irq_r && !vi4_oe)
        else $error("interrupt not cleared by hold request");
    irq_toggle_a: assert property (io_evt && !hold_evt && ce |=> irq_r != $past(irq_r))
        else $error("interrupt did not toggle on strobe");
    buffer_open_a: assert property (c.hold_req && !cpu_hold_ack_n && ce |=> !dma_buffer_enable_n)
        else $error("buffers closed during acknowledged hold");
endmodule

// ### tb/master_board_model.sv
// Behavioural master board driving the backplane select and DMA strobes
`timescale 1ns/1ps
module master_board_model
(
    input  wire logic       aclk,
    input  wire logic       start,
    input  wire logic [2:0] line,
    input  wire logic       from_sat,
    input  wire logic       dma_buffer_enable_n,
    output logic [7:0]      satellite_select_n,
    output logic            dma_mem_request_n,
    output logic            dma_read_strobe,
    output logic            in_xfer,
    output logic            done
);
    int n;
    initial
    begin
        satellite_select_n = 8'hff;
        dma_mem_request_n  = 1'b1;
        dma_read_strobe    = 1'b0;
        in_xfer            = 1'b0;
        done               = 1'b0;
        forever
        begin
            @(posedge aclk);
            // Select only the requested line, then wait up to 8 cycles for the buffers
            if (start && !done)
            begin
                satellite_select_n[line] <= 1'b0;
                n = 0;
                while (dma_buffer_enable_n !== 1'b0 && n < 8)
                begin
                    @(posedge aclk);
                    n++;
                end
                if (dma_buffer_enable_n === 1'b0)
                begin
                    // Source read or destination write on the satellite side
                    dma_read_strobe   <= from_sat;
                    dma_mem_request_n <= 1'b0;
                    in_xfer           <= 1'b1;
                    repeat (6) @(posedge aclk);
                    dma_mem_request_n <= 1'b1;
                    in_xfer           <= 1'b0;
                    @(posedge aclk);
                end
                satellite_select_n <= 8'hff;
                done               <= 1'b1;
            end
            else
            begin
                // Released strobe shows no stale level
                dma_read_strobe <= ~dma_read_strobe;
                if (!start)
                    done <= 1'b0;
            end
        end
    end
endmodule

// ### tb/satellite_bus_slave_tb_top.sv
// Self-checking bench for the satellite bus slave
`timescale 1ns/1ps
module satellite_bus_slave_tb_top;
    typedef struct { logic [31:0] v; int w; } note_s;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, bus_data, seed = 32'h234520d9;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bus_resp;
    logic [15:0] addr = 16'h0, bits;
    logic memory_request_n = 1'b1, read_n = 1'b1, opcode_fetch_cycle_n = 1'b1;
    logic io_request_strobe_n = 1'b1, power_on_jump_n = 1'b1, cpu_hold_ack_n = 1'b1;
    logic [7:0] satellite_select_n;
    logic dma_mem_request_n, dma_read_strobe, vi4_i, vi4_o, vi4_oe;
    logic [6:0] ram_addr;
    logic addr_a, cas_n, ras_inhibit_n, qualified_mem_request, ram_read;
    logic rom_chip_select_n, wait_n, cpu_hold_request_n, dma_buffer_enable_n;
    logic data_to_backplane, in_xfer, done, start = 1'b0, from_sat = 1'b0;
    logic [2:0] line = 3'h0;
    int error_cnt = 0, total_checks = 0, wait_lo = 0, wait_seen = 0, w0;
    note_s q[$], nt;

    satellite_bus_slave DUT
    (
        .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .addr, .memory_request_n, .read_n,
        .opcode_fetch_cycle_n, .io_request_strobe_n, .power_on_jump_n, .cpu_hold_ack_n,
        .satellite_select_n, .dma_mem_request_n, .dma_read_strobe, .vi4_i, .vi4_o, .vi4_oe,
        .ram_addr, .addr_a, .cas_n, .ras_inhibit_n, .qualified_mem_request, .ram_read,
        .rom_chip_select_n, .wait_n, .cpu_hold_request_n, .dma_buffer_enable_n,
        .data_to_backplane
    );

    master_board_model master
    (
        .aclk, .start, .line, .from_sat, .dma_buffer_enable_n, .satellite_select_n,
        .dma_mem_request_n, .dma_read_strobe, .in_xfer, .done
    );

    // Open-drain interrupt wire with pull-up
    assign vi4_i = vi4_oe ? vi4_o : 1'b1;
    assign bits = {1'b0, wait_n, ram_read, data_to_backplane, dma_buffer_enable_n,
                   cpu_hold_request_n, vi4_oe, 1'b0, rom_chip_select_n,
                   qualified_mem_request, ras_inhibit_n, cas_n, addr_a, 3'h0};

    always #2 aclk = ~aclk;
    // Local processor grants hold one cycle after the request
    always @(posedge aclk) cpu_hold_ack_n <= cpu_hold_request_n;
    always @(negedge aclk) wait_lo += (wait_n === 1'b0);

    function automatic logic [31:0] rnd_next(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // 0 read data, 1 response, 2 RAM address, 8 wait count, else one output bit
    function automatic logic [31:0] obs(input int w);
        case (w)
            0: obs = bus_data;
            1: obs = {30'h0, bus_resp};
            2: obs = {25'h0, ram_addr};
            8: obs = wait_seen;
            default: obs = {31'h0, bits[w]};
        endcase
    endfunction

    task automatic note(input logic [31:0] v, input int w);
        q.push_back('{v, w});
    endtask

    always @(negedge aclk)
    begin
        while (q.size() > 0)
        begin
            nt = q.pop_front();
            total_checks++;
            if (obs(nt.w) !== nt.v)
            begin
                error_cnt++;
                $display("BAD %0t item %0d got %h exp %h", $time, nt.w, obs(nt.w), nt.v);
            end
        end
    end

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        bus_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        note(er, 1);
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        bus_data = s_axi_rdata;
        bus_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        note(ed, 0);
        note(er, 1);
        @(posedge aclk);
    endtask

    task automatic mem(input logic [15:0] a, input logic of_n, input logic poj_n,
                       input logic rom);
        w0 = wait_lo;
        addr <= a;
        opcode_fetch_cycle_n <= of_n;
        power_on_jump_n <= poj_n;
        read_n <= a[0];
        memory_request_n <= 1'b0;
        @(posedge aclk);
        note(1, 6);
        note(!a[0], 13);
        note(a[6:0], 2);
        note(!rom, 5);
        @(posedge aclk);
        note(0, 3);
        note(a[13:7], 2);
        note(!rom, 7);
        @(posedge aclk);
        note(0, 4);
        memory_request_n <= 1'b1;
        @(posedge aclk);
        note(1, 4);
        note(0, 6);
        @(posedge aclk);
        wait_seen = wait_lo - w0;
        note(rom && !of_n, 8);
        power_on_jump_n <= 1'b1;
        opcode_fetch_cycle_n <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic io(input logic a7, input logic ev);
        addr <= {8'h0, a7, 7'h0};
        io_request_strobe_n <= 1'b0;
        @(posedge aclk);
        note(ev, 9);
        io_request_strobe_n <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic dma(input logic [2:0] ln, input logic fs, input logic hit);
        line <= ln;
        from_sat <= fs;
        start <= 1'b1;
        if (hit)
        begin
            do @(posedge aclk); while (in_xfer !== 1'b1);
            repeat (2) @(posedge aclk);
            note(0, 10);
            note(0, 11);
            note(fs, 12);
            note(fs, 13);
            note(1, 6);
        end
        do @(posedge aclk); while (done !== 1'b1);
        start <= 1'b0;
        @(posedge aclk);
        note(1, 10);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        conclude();
    end

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        note(1, 3);
        note(1, 4);
        note(1, 7);
        note(1, 14);
        note(1, 10);
        note(0, 9);
        $display("reset test done");
        seed = rnd_next(seed);
        axi_wr(sat_pkg::CTRL_OFS, seed | 32'hffffff00, sat_pkg::RESP_OKAY);
        axi_rd(sat_pkg::CTRL_OFS, seed & 32'hff, sat_pkg::RESP_OKAY);
        axi_wr(4'hc, seed, sat_pkg::RESP_SLVERR);
        axi_rd(4'h8, 32'h0, sat_pkg::RESP_SLVERR);
        axi_wr(sat_pkg::STAT_OFS, 32'hffffffff, sat_pkg::RESP_OKAY);
        axi_wr(sat_pkg::CTRL_OFS, 32'h30, sat_pkg::RESP_OKAY);
        $display("register test done");
        seed = rnd_next(seed);
        mem(seed[15:0] & 16'hefff, 1'b0, 1'b1, 1'b0);
        mem(16'hfc00, 1'b0, 1'b1, 1'b1);
        mem(16'hfbff, 1'b0, 1'b1, 1'b0);
        mem(16'hffff, 1'b1, 1'b1, 1'b1);
        mem(16'h0123, 1'b1, 1'b0, 1'b1);
        axi_wr(sat_pkg::CTRL_OFS, 32'h31, sat_pkg::RESP_OKAY);
        mem(16'hf000, 1'b0, 1'b1, 1'b1);
        mem(16'hefff, 1'b0, 1'b1, 1'b0);
        axi_wr(sat_pkg::CTRL_OFS, 32'h30, sat_pkg::RESP_OKAY);
        $display("memory test done");
        io(1'b0, 1'b0);
        io(1'b1, 1'b1);
        axi_rd(sat_pkg::STAT_OFS, 32'h1 << sat_pkg::ST_IRQ_BIT, sat_pkg::RESP_OKAY);
        dma(3'h5, 1'b1, 1'b0);
        note(1, 9);
        dma(3'h3, 1'b1, 1'b1);
        note(0, 9);
        dma(3'h3, 1'b0, 1'b1);
        note(0, 9);
        @(posedge aclk);
        $display("dma test done");
        conclude();
    end
endmodule
